// ### rtl/mfce_buffer.sv
// Two-entry skid buffer for transmit bytes.
// Assumes both sides run on clk; outputs come from flip-flops.
`timescale 1ns/10ps
`default_nettype none
module mfce_buffer
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       inValid,
  output logic            inReady,
  input  wire logic [7:0] inData,
  output logic            outValid,
  input  wire logic       outReady,
  output logic [7:0]      outData
);

  logic [7:0] entry_r [2];
  logic       skidValid_r;
  logic       outValid_r;
  logic       inTake;

  // Input is refused only while the spare entry holds a word.
  assign inReady  = ~skidValid_r;
  assign inTake   = inValid & ~skidValid_r;
  assign outValid = outValid_r;
  assign outData  = entry_r[0];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outValid_r  <= 1'b0;
      skidValid_r <= 1'b0;
      entry_r[0]  <= 8'h00;
      entry_r[1]  <= 8'h00;
    end
    else if (outReady || !outValid_r)
    begin
      if (skidValid_r)
      begin
        entry_r[0]  <= entry_r[1];
        skidValid_r <= 1'b0;
        outValid_r  <= 1'b1;
      end
      else
      begin
        entry_r[0] <= inData;
        outValid_r <= inTake;
      end
    end
    else if (inTake)
    begin
      entry_r[1]  <= inData;
      skidValid_r <= 1'b1;
    end
  end

endmodule : mfce_buffer
`default_nettype wire

// ### rtl/mfce_defines.svh
// Constants of the memory function command engine: codes, offsets, layouts, timing.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef MFCE_DEFINES_SVH
`define MFCE_DEFINES_SVH

// ------
// Command codes
// ------
`define MFCE_CMD_WRITE_SP   8'h0f
`define MFCE_CMD_READ_SP    8'haa
`define MFCE_CMD_COPY_SP    8'h55
`define MFCE_CMD_READ_MEM   8'hf0
`define MFCE_CMD_READ_CRC   8'ha5
`define MFCE_CMD_CLEAR      8'h3c
`define MFCE_CMD_CONVERT    8'h44

// ------
// Addresses and field positions
// ------
`define MFCE_PROT_LO        16'h0200
`define MFCE_PROT_HI        16'h0213
`define MFCE_TEMP_ADDR      16'h0211
`define MFCE_MEM_TOP        16'h7fff
`define MFCE_SP_LAST        5'h1f
`define MFCE_ES_PF_BIT      5
`define MFCE_ES_ZERO_BIT    6
`define MFCE_ES_AA_BIT      7
`define MFCE_CRC_POLY       16'ha001
`define MFCE_FILL_ONES      8'hff
`define MFCE_FILL_ALT       8'haa

// ------
// Timing
// ------
`define MFCE_CLK_NS         8
`define MFCE_COPY_NS        2000
`define MFCE_CLEAR_NS       500000
`define MFCE_COPY_CYC       ((`MFCE_COPY_NS + `MFCE_CLK_NS - 1) / `MFCE_CLK_NS)
`define MFCE_CLEAR_CYC      ((`MFCE_CLEAR_NS + `MFCE_CLK_NS - 1) / `MFCE_CLK_NS)

`endif

// ### rtl/mfce_engine.sv
// Memory function command interpreter of a serial temperature logger.
// Assumes a link layer on clk that moves whole bytes and reports reset pulses.
// Functional notes
// - Link timing follows the speed flag: regular when 0, overdrive when 1.
// - Write scratchpad takes two address bytes, stores data, records end offset.
// - An incomplete last write byte is dropped and sets the partial flag.
// - Write CRC starts cleared, covers command, both address bytes and data.
// - With end offset all ones, the write CRC follows in sixteen read slots.
// - Register page 200h to 213h is write protected during a mission.
// - Read scratchpad sends address, end/status, then data to scratchpad end.
// - Read scratchpad ends with CRC over command and all sent bytes, then ones.
// - Copy needs three authorization bytes matching address and status registers.
// - After copy send alternating bits; bus resets ignored while copying.
// - Copy moves scratchpad start through end offset to target address.
// - Only a scratchpad write clears the copy authorized flag.
// - Memory read loads the address, streams to memory end, then ones.
// - CRC memory read streams each page followed by its CRC.
// - First page CRC includes command and address; later pages only data.
// - After the last page CRC send ones; a bus reset aborts anytime.
// - Memory clear erases from 220h up and the mission registers.
// - Clear runs only if enabled; other valid commands disable it.
// - Clear lasts about 500 us, runs on while other accesses continue.
// - Clear completion sets the done flag and drops the enable bit.
// - Conversion starts only without a mission; result lands at 211h.
// - End/status holds end offset, partial flag, zero bit, authorized flag.
// - A long bus reset returns the speed flag to regular.
`timescale 1ns/10ps
`default_nettype none
`include "mfce_defines.svh"
module mfce_engine
#(
  parameter int CLEAR_CYCLES = `MFCE_CLEAR_CYC
)
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire mfce_pkg::mfce_rx_type rxByte,
  input  wire logic                 busReset,
  input  wire logic                 busResetLong,
  input  wire logic                 speedSet,
  output logic                      speedSelectFlag_r,
  output logic                      txValid,
  input  wire logic                 txReady,
  output logic [7:0]                txData,
  output mfce_pkg::mfce_mem_type    memReq_r,
  input  wire logic [7:0]           memRdata,
  input  wire logic                 missionActive,
  input  wire logic                 clearEnableSet,
  output logic                      clearEnable_r,
  input  wire logic                 clearDoneClr,
  output logic                      clearDone_r,
  output logic                      clearStart_r,
  output logic                      tempStart_r,
  input  wire logic                 tempDone,
  input  wire logic [7:0]           tempResult
);

  // ------
  // Helpers
  // ------
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MFCE_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte

  function automatic logic isValidCmd(input logic [7:0] c);
    return c == `MFCE_CMD_WRITE_SP || c == `MFCE_CMD_READ_SP || c == `MFCE_CMD_COPY_SP ||
           c == `MFCE_CMD_READ_MEM || c == `MFCE_CMD_READ_CRC || c == `MFCE_CMD_CLEAR ||
           c == `MFCE_CMD_CONVERT;
  endfunction : isValidCmd

  // ------
  // Storage
  // ------
  mfce_pkg::mfce_state_type state_r;
  mfce_pkg::mfce_state_type afterCrc_r;
  logic [7:0]  scratch_r [32];
  logic [7:0]  addrLow_r;
  logic [7:0]  addrHigh_r;
  logic [4:0]  endOffset_r;
  logic        partialFlag_r;
  logic        copyAuthFlag_r;
  logic [15:0] crc_r;
  logic [4:0]  offset_r;
  logic [1:0]  index_r;
  logic        mismatch_r;
  logic        crcMode_r;
  logic [15:0] readAddr_r;
  logic [7:0]  readBuf_r;
  logic [7:0]  fillByte_r;
  logic [7:0]  copyCnt_r;
  logic        txLoad_r;
  logic [7:0]  txByte_r;
  logic        bufInReady;
  logic        canLoad;
  logic        cmdTake;
  logic [7:0]  esByte;
  logic [7:0]  rsByte;
  logic [4:0]  startOffset;
  logic [15:0] copyAddr;
  logic        copyWrite;
  logic        tempServe;
  logic        clearBusy_r;
  logic [19:0] clearCnt_r;
  logic        tempBusy_r;
  logic        tempPend_r;
  logic [7:0]  tempVal_r;

  assign startOffset = addrLow_r[4:0];
  assign esByte      = {copyAuthFlag_r, 1'b0, partialFlag_r, endOffset_r};
  assign canLoad     = ~txLoad_r | bufInReady;
  assign cmdTake     = (state_r == mfce_pkg::ST_IDLE) && rxByte.valid && !busReset;
  assign rsByte      = (index_r == 2'd0) ? addrLow_r :
                       (index_r == 2'd1) ? addrHigh_r :
                       (index_r == 2'd2) ? esByte : scratch_r[offset_r];
  assign copyAddr    = {addrHigh_r, addrLow_r} + {11'h000, 5'(offset_r - startOffset)};
  assign copyWrite   = (state_r == mfce_pkg::ST_CP_RUN) && (copyCnt_r == 8'(`MFCE_COPY_CYC - 1));
  assign tempServe   = tempPend_r && (state_r != mfce_pkg::ST_MR_REQ) && !copyWrite;

  // ------
  // Command sequencer
  // ------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r        <= mfce_pkg::ST_IDLE;
      afterCrc_r     <= mfce_pkg::ST_FILL;
      addrLow_r      <= 8'h00;
      addrHigh_r     <= 8'h00;
      endOffset_r    <= 5'h00;
      partialFlag_r  <= 1'b0;
      copyAuthFlag_r <= 1'b0;
      crc_r          <= 16'h0000;
      offset_r       <= 5'h00;
      index_r        <= 2'd0;
      mismatch_r     <= 1'b0;
      crcMode_r      <= 1'b0;
      readAddr_r     <= 16'h0000;
      readBuf_r      <= 8'h00;
      fillByte_r     <= `MFCE_FILL_ONES;
      copyCnt_r      <= 8'h00;
      txLoad_r       <= 1'b0;
      txByte_r       <= 8'h00;
    end
    else if (busReset && state_r != mfce_pkg::ST_CP_RUN)
    begin
      state_r  <= mfce_pkg::ST_IDLE;
      txLoad_r <= 1'b0;
    end
    else
    begin
      if (txLoad_r && bufInReady)
        txLoad_r <= 1'b0;
      unique case (state_r)
        mfce_pkg::ST_IDLE:
          if (rxByte.valid)
          begin
            crc_r      <= crcByte(16'h0000, rxByte.data);
            index_r    <= 2'd0;
            mismatch_r <= 1'b0;
            fillByte_r <= `MFCE_FILL_ONES;
            offset_r   <= startOffset;
            unique case (rxByte.data)
              `MFCE_CMD_WRITE_SP:
              begin
                state_r        <= mfce_pkg::ST_WS_A0;
                partialFlag_r  <= 1'b0;
                copyAuthFlag_r <= 1'b0;
              end
              `MFCE_CMD_READ_SP:  state_r <= mfce_pkg::ST_RS;
              `MFCE_CMD_COPY_SP:  state_r <= mfce_pkg::ST_CP_AUTH;
              `MFCE_CMD_READ_MEM:
              begin
                state_r   <= mfce_pkg::ST_MR_A0;
                crcMode_r <= 1'b0;
              end
              `MFCE_CMD_READ_CRC:
              begin
                state_r   <= mfce_pkg::ST_MR_A0;
                crcMode_r <= 1'b1;
              end
              default: state_r <= mfce_pkg::ST_WAIT;
            endcase
          end
        mfce_pkg::ST_WAIT: ;
        mfce_pkg::ST_FILL:
          if (canLoad)
          begin
            txLoad_r <= 1'b1;
            txByte_r <= fillByte_r;
          end
        mfce_pkg::ST_WS_A0, mfce_pkg::ST_WS_A1:
          if (rxByte.valid)
          begin
            crc_r <= crcByte(crc_r, rxByte.data);
            if (state_r == mfce_pkg::ST_WS_A0)
            begin
              addrLow_r <= rxByte.data;
              offset_r  <= rxByte.data[4:0];
              state_r   <= mfce_pkg::ST_WS_A1;
            end
            else
            begin
              addrHigh_r <= rxByte.data;
              state_r    <= mfce_pkg::ST_WS_D;
            end
          end
        mfce_pkg::ST_WS_D:
          if (rxByte.partial)
            partialFlag_r <= 1'b1;
          else if (rxByte.valid)
          begin
            scratch_r[offset_r] <= rxByte.data;
            endOffset_r         <= offset_r;
            crc_r               <= crcByte(crc_r, rxByte.data);
            if (offset_r == `MFCE_SP_LAST)
            begin
              state_r    <= mfce_pkg::ST_CRC_LO;
              afterCrc_r <= mfce_pkg::ST_FILL;
            end
            else
              offset_r <= offset_r + 5'h01;
          end
        mfce_pkg::ST_RS:
          if (canLoad)
          begin
            txLoad_r <= 1'b1;
            txByte_r <= rsByte;
            crc_r    <= crcByte(crc_r, rsByte);
            if (index_r != 2'd3)
              index_r <= index_r + 2'd1;
            else if (offset_r == `MFCE_SP_LAST)
            begin
              state_r    <= mfce_pkg::ST_CRC_LO;
              afterCrc_r <= mfce_pkg::ST_FILL;
            end
            else
              offset_r <= offset_r + 5'h01;
          end
        mfce_pkg::ST_CP_AUTH:
          if (rxByte.valid)
          begin
            if (index_r == 2'd2)
            begin
              if (!mismatch_r && rxByte.data == rsByte)
              begin
                copyAuthFlag_r <= 1'b1;
                state_r        <= mfce_pkg::ST_CP_RUN;
                copyCnt_r      <= 8'h00;
                fillByte_r     <= `MFCE_FILL_ALT;
              end
              else
                state_r <= mfce_pkg::ST_WAIT;
            end
            else
            begin
              mismatch_r <= mismatch_r | (rxByte.data != rsByte);
              index_r    <= index_r + 2'd1;
            end
          end
        mfce_pkg::ST_CP_RUN:
          if (copyWrite)
          begin
            copyCnt_r <= 8'h00;
            if (offset_r == endOffset_r || offset_r == `MFCE_SP_LAST)
              state_r <= mfce_pkg::ST_FILL;
            else
              offset_r <= offset_r + 5'h01;
          end
          else
            copyCnt_r <= copyCnt_r + 8'h01;
        mfce_pkg::ST_MR_A0, mfce_pkg::ST_MR_A1:
          if (rxByte.valid)
          begin
            crc_r <= crcByte(crc_r, rxByte.data);
            if (state_r == mfce_pkg::ST_MR_A0)
            begin
              addrLow_r <= rxByte.data;
              state_r   <= mfce_pkg::ST_MR_A1;
            end
            else
            begin
              addrHigh_r <= rxByte.data;
              readAddr_r <= {rxByte.data, addrLow_r};
              state_r    <= mfce_pkg::ST_MR_REQ;
            end
          end
        mfce_pkg::ST_MR_REQ:  state_r <= mfce_pkg::ST_MR_WAIT;
        mfce_pkg::ST_MR_WAIT: state_r <= mfce_pkg::ST_MR_GET;
        mfce_pkg::ST_MR_GET:
        begin
          readBuf_r <= memRdata;
          state_r   <= mfce_pkg::ST_MR_PUSH;
        end
        mfce_pkg::ST_MR_PUSH:
          if (canLoad)
          begin
            txLoad_r   <= 1'b1;
            txByte_r   <= readBuf_r;
            crc_r      <= crcByte(crc_r, readBuf_r);
            readAddr_r <= readAddr_r + 16'h0001;
            if (crcMode_r && (readAddr_r[4:0] == `MFCE_SP_LAST || readAddr_r == `MFCE_MEM_TOP))
            begin
              state_r    <= mfce_pkg::ST_CRC_LO;
              afterCrc_r <= (readAddr_r == `MFCE_MEM_TOP) ? mfce_pkg::ST_FILL : mfce_pkg::ST_MR_REQ;
            end
            else if (readAddr_r == `MFCE_MEM_TOP)
              state_r <= mfce_pkg::ST_FILL;
            else
              state_r <= mfce_pkg::ST_MR_REQ;
          end
        mfce_pkg::ST_CRC_LO:
          if (canLoad)
          begin
            txLoad_r <= 1'b1;
            txByte_r <= ~crc_r[7:0];
            state_r  <= mfce_pkg::ST_CRC_HI;
          end
        mfce_pkg::ST_CRC_HI:
          if (canLoad)
          begin
            txLoad_r <= 1'b1;
            txByte_r <= ~crc_r[15:8];
            state_r  <= afterCrc_r;
            if (afterCrc_r == mfce_pkg::ST_MR_REQ)
              crc_r <= 16'h0000;
          end
      endcase
    end
  end

  // ------
  // Memory port
  // ------
  // Protected register writes are dropped silently so the copy keeps its pace.
  always_ff @(posedge clk)
  begin
    if (srst)
      memReq_r <= '0;
    else
    begin
      memReq_r <= '0;
      if (state_r == mfce_pkg::ST_MR_REQ)
      begin
        memReq_r.re   <= 1'b1;
        memReq_r.addr <= readAddr_r;
      end
      else if (copyWrite)
      begin
        memReq_r.we    <= !(missionActive && copyAddr >= `MFCE_PROT_LO &&
                            copyAddr <= `MFCE_PROT_HI);
        memReq_r.addr  <= copyAddr;
        memReq_r.wdata <= scratch_r[offset_r];
      end
      else if (tempServe)
      begin
        memReq_r.we    <= 1'b1;
        memReq_r.addr  <= `MFCE_TEMP_ADDR;
        memReq_r.wdata <= tempVal_r;
      end
    end
  end

  // ------
  // Memory clear
  // ------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clearEnable_r <= 1'b0;
      clearDone_r   <= 1'b0;
      clearBusy_r   <= 1'b0;
      clearStart_r  <= 1'b0;
      clearCnt_r    <= 20'h00000;
    end
    else
    begin
      clearStart_r <= 1'b0;
      if (clearEnableSet)
        clearEnable_r <= 1'b1;
      else if (cmdTake && isValidCmd(rxByte.data) && rxByte.data != `MFCE_CMD_CLEAR)
        clearEnable_r <= 1'b0;
      else if (clearBusy_r && clearCnt_r == 20'(CLEAR_CYCLES - 1))
        clearEnable_r <= 1'b0;
      if (clearBusy_r && clearCnt_r == 20'(CLEAR_CYCLES - 1))
        clearDone_r <= 1'b1;
      else if (clearDoneClr)
        clearDone_r <= 1'b0;
      if (cmdTake && rxByte.data == `MFCE_CMD_CLEAR && clearEnable_r && !clearBusy_r)
      begin
        clearBusy_r  <= 1'b1;
        clearStart_r <= 1'b1;
        clearCnt_r   <= 20'h00000;
      end
      else if (clearBusy_r)
      begin
        clearCnt_r <= clearCnt_r + 20'h00001;
        if (clearCnt_r == 20'(CLEAR_CYCLES - 1))
          clearBusy_r <= 1'b0;
      end
    end
  end

  // ------
  // Temperature conversion and speed
  // ------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tempStart_r <= 1'b0;
      tempBusy_r  <= 1'b0;
      tempPend_r  <= 1'b0;
      tempVal_r   <= 8'h00;
    end
    else
    begin
      tempStart_r <= 1'b0;
      if (cmdTake && rxByte.data == `MFCE_CMD_CONVERT && !missionActive && !tempBusy_r)
      begin
        tempStart_r <= 1'b1;
        tempBusy_r  <= 1'b1;
      end
      else if (tempBusy_r && tempDone)
        tempBusy_r <= 1'b0;
      if (tempBusy_r && tempDone)
      begin
        tempPend_r <= 1'b1;
        tempVal_r  <= tempResult;
      end
      else if (tempServe)
        tempPend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      speedSelectFlag_r <= 1'b0;
    else if (speedSet)
      speedSelectFlag_r <= 1'b1;
    else if (busResetLong)
      speedSelectFlag_r <= 1'b0;
  end

  mfce_buffer txBuf
  (
    .clk      (clk),
    .srst     (srst),
    .inValid  (txLoad_r),
    .inReady  (bufInReady),
    .inData   (txByte_r),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (txData)
  );

endmodule : mfce_engine
`default_nettype wire

// ### rtl/mfce_pkg.sv
// Types shared by the command engine and its tests.
// Assumes mfce_defines.svh is compiled alongside.
package mfce_pkg;

  // ------
  // Carriers
  // ------
  typedef struct packed {
    logic       valid;
    logic       partial;
    logic [7:0] data;
  } mfce_rx_type;

  typedef struct packed {
    logic        re;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mfce_mem_type;

  // ------
  // Sequencer states
  // ------
  typedef enum logic [4:0] {
    ST_IDLE, ST_WAIT, ST_FILL,
    ST_WS_A0, ST_WS_A1, ST_WS_D,
    ST_RS,
    ST_CP_AUTH, ST_CP_RUN,
    ST_MR_A0, ST_MR_A1, ST_MR_REQ, ST_MR_WAIT, ST_MR_GET, ST_MR_PUSH,
    ST_CRC_LO, ST_CRC_HI
  } mfce_state_type;

endpackage : mfce_pkg

// ### tb/mfce_engine_properties.sv
// Port assertions of the command engine.
// Assumes one clock domain with the synchronous reset srst.
`timescale 1ns/10ps
`default_nettype none
module mfce_engine_properties
#(
  parameter int CLEAR_CYCLES = 50
)
(
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   busResetLong,
  input wire logic                   speedSet,
  input wire logic                   speedSelectFlag_r,
  input wire logic                   txValid,
  input wire logic                   txReady,
  input wire logic [7:0]             txData,
  input wire mfce_pkg::mfce_mem_type memReq_r,
  input wire logic                   missionActive,
  input wire logic                   clearEnable_r,
  input wire logic                   clearDone_r,
  input wire logic                   clearStart_r,
  input wire logic                   tempStart_r,
  input wire logic                   tempDone
);
  // ------
  // Checks
  // ------
  // The window allows one cycle of slack below and two cycles above the nominal clear length.
  localparam int CL = CLEAR_CYCLES - 1;
  localparam int CH = CLEAR_CYCLES + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_speed_up: assert property (speedSet |=> speedSelectFlag_r)
    else $error("speed flag not set");
  chk_speed_down: assert property (busResetLong && !speedSet |=> !speedSelectFlag_r)
    else $error("speed flag not cleared");
  chk_speed_hold: assert property (!speedSet && !busResetLong |=> $stable(speedSelectFlag_r))
    else $error("speed flag moved");
  chk_tx_stands: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte dropped");
  chk_clear_gate: assert property (clearStart_r |-> $past(clearEnable_r))
    else $error("clear without enable");
  chk_clear_ends: assert property (clearStart_r |-> ##[CL:CH] (clearDone_r && !clearEnable_r))
    else $error("clear did not complete");
  chk_done_drop: assert property ($rose(clearDone_r) |-> !clearEnable_r)
    else $error("enable left set");
  chk_write_protect: assert property (memReq_r.we && missionActive |->
    !(memReq_r.addr >= 16'h0200 && memReq_r.addr <= 16'h0213))
    else $error("protected write");
  chk_temp_gate: assert property (tempStart_r |-> !$past(missionActive))
    else $error("conversion during mission");
  chk_temp_store: assert property (tempDone |-> ##[1:40] (memReq_r.we && memReq_r.addr == 16'h0211))
    else $error("result not stored");
  cover property (clearStart_r);
  cover property (txValid && !txReady ##1 txValid);
  cover property (memReq_r.we);
endmodule : mfce_engine_properties
bind mfce_engine mfce_engine_properties #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_props
  (.clk(clk), .srst(srst), .busResetLong(busResetLong), .speedSet(speedSet),
   .speedSelectFlag_r(speedSelectFlag_r), .txValid(txValid), .txReady(txReady),
   .txData(txData), .memReq_r(memReq_r), .missionActive(missionActive),
   .clearEnable_r(clearEnable_r), .clearDone_r(clearDone_r),
   .clearStart_r(clearStart_r), .tempStart_r(tempStart_r), .tempDone(tempDone));
`default_nettype wire

// ### tb/mfce_far_model.sv
// Model of the memory array and temperature sensor beside the engine.
// Assumes one clock; reads answer one cycle after the request.
`timescale 1ns/10ps
`default_nettype none
module mfce_far_model
(
  input  wire logic                   clk,
  input  wire mfce_pkg::mfce_mem_type memReq,
  output logic [7:0]                  memRdata,
  input  wire logic                   tempStart,
  output logic                        tempDone,
  output logic [7:0]                  tempResult
);
  logic [7:0] wmem [256];
  int         tcnt = 0;
  initial
  begin
    memRdata = 8'h00;
    tempDone = 1'b0;
    tempResult = 8'h00;
    foreach (wmem[i]) wmem[i] = 8'h00;
  end
  // Idle data churns every cycle, so a late sample never matches by luck.
  always @(posedge clk)
  begin
    memRdata <= memReq.re ? (memReq.addr[7:0] ^ memReq.addr[15:8]) : ~memRdata;
    if (memReq.we) wmem[memReq.addr[7:0]] <= memReq.wdata;
    tempDone <= (tcnt == 1);
    tempResult <= (tcnt == 1) ? 8'h3a : ~tempResult;
    tcnt <= tempStart ? 40 : ((tcnt > 0) ? tcnt - 1 : 0);
  end
endmodule : mfce_far_model
`default_nettype wire

// ### tb/tb_memory_function_command_engine.sv
// Self-checking bench of the command engine with its far-side model.
// Assumes the checker binds itself to the engine.
`timescale 1ns/10ps
`default_nettype none
module tb_memory_function_command_engine;
  logic clk = 1'b0, srst = 1'b1, busReset = 1'b0, busResetLong = 1'b0, speedSet = 1'b0;
  logic txReady = 1'b1, missionActive = 1'b0, clearEnableSet = 1'b0, clearDoneClr = 1'b0;
  logic speedSelectFlag_r, txValid, clearEnable_r, clearDone_r, clearStart_r, tempStart_r;
  logic tempDone;
  logic [7:0] txData, memRdata, tempResult;
  logic [7:0] wr [7] = '{8'h0f, 8'hfc, 8'h01, 8'h11, 8'h22, 8'h33, 8'h44};
  logic [15:0] c;
  mfce_pkg::mfce_rx_type  rxByte = '0;
  mfce_pkg::mfce_mem_type memReq_r;
  int error_cnt = 0, num_checks = 0, cycles = 0;
  mfce_engine #(.CLEAR_CYCLES(50)) DUT (.clk(clk), .srst(srst), .rxByte(rxByte),
    .busReset(busReset), .busResetLong(busResetLong), .speedSet(speedSet),
    .speedSelectFlag_r(speedSelectFlag_r), .txValid(txValid), .txReady(txReady),
    .txData(txData), .memReq_r(memReq_r), .memRdata(memRdata), .missionActive(missionActive),
    .clearEnableSet(clearEnableSet), .clearEnable_r(clearEnable_r),
    .clearDoneClr(clearDoneClr), .clearDone_r(clearDone_r), .clearStart_r(clearStart_r),
    .tempStart_r(tempStart_r), .tempDone(tempDone), .tempResult(tempResult));
  mfce_far_model far (.clk(clk), .memReq(memReq_r), .memRdata(memRdata),
    .tempStart(tempStart_r), .tempDone(tempDone), .tempResult(tempResult));
  always #4 clk = ~clk;
  // ------
  // Helpers
  // ------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // Reflected CRC16 from a cleared start; sent inverted.
  function automatic logic [15:0] crc(input logic [15:0] r, input logic [7:0] d);
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    return r;
  endfunction : crc
  task automatic put(input logic p, input logic [7:0] d);
    rxByte <= '{~p, p, d};
    @(posedge clk);
    rxByte <= '0;
    @(posedge clk);
  endtask : put
  task automatic brst();
    busReset <= 1'b1;
    @(posedge clk);
    busReset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : brst
  task automatic get(input logic [7:0] e);
    int n = 0;
    txReady <= 1'b1;
    do @(posedge clk); while (!(txValid === 1'b1 && txReady === 1'b1) && ++n < 2000);
    chk(txData, e);
  endtask : get
  // ------
  // Scenarios
  // ------
  task automatic t_speed();
    speedSet <= 1'b1;
    @(posedge clk);
    speedSet <= 1'b0;
    @(posedge clk);
    chk(speedSelectFlag_r, 1'b1);
    busResetLong <= 1'b1;
    @(posedge clk);
    busResetLong <= 1'b0;
    @(posedge clk);
    chk(speedSelectFlag_r, 1'b0);
  endtask : t_speed
  task automatic t_write_read();
    c = 16'h0000;
    foreach (wr[i]) put(1'b0, wr[i]);
    foreach (wr[i]) c = crc(c, wr[i]);
    get(~c[7:0]);
    get(~c[15:8]);
    brst();
    txReady <= 1'b0;
    put(1'b0, 8'haa);
    repeat (30) @(posedge clk);
    chk(txValid, 1'b1);
    c = crc(crc(crc(crc(16'h0000, 8'haa), 8'hfc), 8'h01), 8'h1f);
    get(8'hfc);
    get(8'h01);
    get(8'h1f);
    for (int i = 3; i < 7; i++) get(wr[i]);
    for (int i = 3; i < 7; i++) c = crc(c, wr[i]);
    get(~c[7:0]);
    get(~c[15:8]);
    get(8'hff);
    brst();
  endtask : t_write_read
  task automatic t_copy();
    for (int i = 0; i < 4; i++) put(1'b0, (i == 0) ? 8'h55 : (i == 3) ? 8'h1f : wr[i]);
    get(8'haa);
    get(8'haa);
    for (int i = 0; i < 4; i++) chk(far.wmem[252 + i], wr[3 + i]);
    brst();
    put(1'b0, 8'haa);
    get(8'hfc);
    get(8'h01);
    get(8'h9f);
    brst();
  endtask : t_copy
  task automatic t_clear_read();
    clearEnableSet <= 1'b1;
    @(posedge clk);
    clearEnableSet <= 1'b0;
    put(1'b0, 8'h3c);
    repeat (60) @(posedge clk);
    chk(clearDone_r, 1'b1);
    chk(clearEnable_r, 1'b0);
    brst();
    clearDoneClr <= 1'b1;
    clearEnableSet <= 1'b1;
    @(posedge clk);
    clearDoneClr <= 1'b0;
    clearEnableSet <= 1'b0;
    put(1'b0, 8'hf0);
    put(1'b0, 8'hfe);
    put(1'b0, 8'h7f);
    get(8'h81);
    get(8'h80);
    get(8'hff);
    chk({clearDone_r, clearEnable_r}, 2'b00);
    brst();
    put(1'b0, 8'ha5);
    put(1'b0, 8'hfe);
    put(1'b0, 8'h7f);
    c = crc(crc(crc(crc(crc(16'h0000, 8'ha5), 8'hfe), 8'h7f), 8'h81), 8'h80);
    get(8'h81);
    get(8'h80);
    get(~c[7:0]);
    get(~c[15:8]);
    get(8'hff);
    brst();
  endtask : t_clear_read
  task automatic t_convert();
    missionActive <= 1'b1;
    put(1'b0, 8'h44);
    repeat (80) @(posedge clk);
    chk(far.wmem[17], 8'h00);
    brst();
    missionActive <= 1'b0;
    put(1'b0, 8'h44);
    repeat (80) @(posedge clk);
    chk(far.wmem[17], 8'h3a);
    brst();
  endtask : t_convert
  task automatic t_partial();
    foreach (wr[i]) if (i < 4) put(1'b0, (i == 1) ? 8'he0 : wr[i]);
    put(1'b1, 8'h00);
    brst();
    put(1'b0, 8'haa);
    get(8'he0);
    get(8'h01);
    get(8'h20);
    brst();
  endtask : t_partial
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(speedSelectFlag_r, 1'b0);
    t_speed();
    t_write_read();
    t_copy();
    t_clear_read();
    t_convert();
    t_partial();
    report_and_stop();
  end
endmodule : tb_memory_function_command_engine
`default_nettype wire
